/* File: gcm_pkg.sv */
package gcm_pkg;
   // Configuration port pair and register indexes
   localparam logic [15:0] GCM_PORT_PRI = 16'h002e;
   localparam logic [15:0] GCM_PORT_ALT = 16'h004e;
   localparam logic [7:0] GCM_IDX_IRQ_CLK = 8'h26;
   localparam logic [7:0] GCM_IDX_ROM_SEL = 8'h27;
   localparam logic [7:0] GCM_IDX_PIN_A = 8'h28;
   localparam logic [7:0] GCM_IDX_MULTI_B = 8'h29;
   // Writable bit masks; other bits read zero
   localparam logic [7:0] GCM_MASK_IRQ_CLK = 8'h83;
   localparam logic [7:0] GCM_MASK_ROM_SEL = 8'hff;
   localparam logic [7:0] GCM_MASK_PIN_A = 8'h0f;
   localparam logic [7:0] GCM_MASK_MULTI_B = 8'h77;
   // Reset values, strap bits excluded
   localparam logic [7:0] GCM_RST_IRQ_CLK = 8'h00;
   localparam logic [7:0] GCM_RST_ROM_SEL = 8'h00;
   localparam logic [7:0] GCM_RST_PIN_A = 8'h00;
   localparam logic [7:0] GCM_RST_MULTI_B = 8'h00;
   localparam logic [7:0] GCM_RST_INDEX = 8'h00;
   // Field positions
   localparam int GCM_B_CLK_SEL = 7;
   localparam int GCM_B_IRQ_MODE = 1;
   localparam int GCM_B_IRQ_SHARE = 0;
   localparam int GCM_B_ROM_WR = 7;
   localparam int GCM_B_FLASH_IF = 6;
   localparam int GCM_B_BRIDGE = 5;
   localparam int GCM_B_PORT_ALT = 4;
   localparam int GCM_B_SEG_E = 3;
   localparam int GCM_B_TOP512 = 2;
   localparam int GCM_B_UP128 = 1;
   localparam int GCM_B_MID512 = 0;
   localparam int GCM_B_FDD_PROT = 6;
   localparam int GCM_B_LED_RET = 5;
   localparam int GCM_B_KM_SWAP = 4;
   localparam int GCM_B_SLOT = 2;
   localparam int GCM_B_WDOG = 1;
   localparam int GCM_B_ALERT = 0;
   // Firmware windows: base and address mask of the fixed bits
   localparam logic [31:0] GCM_WIN_E_BASE = 32'h000e0000;
   localparam logic [31:0] GCM_WIN_F_BASE = 32'h000f0000;
   localparam logic [31:0] GCM_WIN_64K_MASK = 32'hffff0000;
   localparam logic [31:0] GCM_WIN_TOP_BASE = 32'hfff80000;
   localparam logic [31:0] GCM_WIN_MID_BASE = 32'hfff00000;
   localparam logic [31:0] GCM_WIN_512K_MASK = 32'hfff80000;
   localparam logic [31:0] GCM_WIN_UP_BASE = 32'hffee0000;
   localparam logic [31:0] GCM_WIN_128K_MASK = 32'hfffe0000;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } gcm_io_req_type;

   typedef struct packed {
      logic input_clock_freq_sel;
      logic irq_pulse_mode;
      logic serial_irq_share_en;
      logic flash_if_en;
      logic boot_flash_bridge_sel;
      logic config_port_alt_sel;
      logic [3:0] pin_gpio_sel;
      logic keyboard_mouse_swap;
      logic slot_pin_sel;
      logic watchdog_pin_sel;
      logic alert_pin_sel;
   } gcm_cfg_type;
endpackage

/* File: gcm_global_config.sv */
`timescale 1ns/1ps
// Functional notes
// - Clock select bit: 0 means 48MHz input clock, 1 means 24MHz; resets 0.
// - Interrupt style bit: 0 shared line is low level, 1 is low pulse.
// - Share bit 1 merges both serial interrupts on one line; resets 0.
// - Firmware ROM writes blocked unless ROM write enable set; resets 0.
// - Flash interface enable loads from strap, low strap enables; software rewritable.
// - Boot bridge bit loads from strap, low enables; 0 routes firmware via bridge.
// - Port select: 0 uses 2E/2F, 1 uses 4E/4F; low strap selects 2E/2F.
// - E segment window 0x000E0000-0x000EFFFF decodes as ROM when enabled.
// - Top 512KB at 0xFFF80000 plus F segment decode when enabled.
// - 128KB window at 0xFFEE0000 decodes as ROM when enabled.
// - 512KB window at 0xFFF00000 decodes as ROM when enabled; resets 0.
// - E segment, top 512KB and 128KB enables share one strap, low enables.
// - Bits 3..0 select GPIO when set, else infrared, fan drive, fan tach.
// - Floppy protect 0 follows protect pin, 1 always reports write protected.
// - LED retain 0 floats main LED on power loss, 1 keeps control.
// - Swap bit 1 exchanges keyboard and mouse signals.
// - Slot select: 0 slot occupied input, 1 general purpose I/O 02.
// - Watchdog select: 0 general purpose I/O 03, 1 watchdog reset output.
// - Alert select 1 gives alert output, 0 leaves GPIO15 or standby LED.
// - Register 29h lives in standby domain, survives main supply loss.
module gcm_global_config (
   // Clock and resets
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic stby_rst_i,
   // Straps
   input wire logic flash_if_strap_i,
   input wire logic boot_bridge_strap_i,
   input wire logic config_port_strap_i,
   input wire logic decode_window_strap_i,
   // Configuration port
   input wire gcm_pkg::gcm_io_req_type io_req_i,
   output logic [7:0] io_rdata_o,
   output logic io_ack_o,
   // Host memory cycles
   input wire logic [31:0] mem_addr_i,
   input wire logic mem_valid_i,
   input wire logic mem_write_i,
   output logic rom_sel_o,
   output logic rom_write_o,
   // Serial port interrupts
   input wire logic uart1_irq_i,
   input wire logic uart2_irq_i,
   output logic uart1_irq_n_o,
   output logic uart2_irq_n_o,
   // Floppy and LED
   input wire logic floppy_protect_input_n_i,
   output logic floppy_protected_o,
   input wire logic main_power_ok_i,
   input wire logic main_supply_led_i,
   output logic main_supply_led_o,
   output logic main_supply_led_oe_n_o,
   // Configuration to the pin mux and clocking
   output gcm_pkg::gcm_cfg_type cfg_o
);
   import gcm_pkg::*;

   logic [7:0] index_reg;
   logic [7:0] irq_clk_reg;
   logic [7:0] rom_sel_reg;
   logic [7:0] pin_a_reg;
   logic [7:0] multi_b_reg;
   logic [7:0] rom_sel_next;
   logic strap_load_reg;
   logic irq_any_reg;
   logic [7:0] io_rdata_reg;
   logic io_ack_reg;
   logic rom_sel_q_reg;
   logic rom_write_q_reg;
   logic irq1_n_reg;
   logic irq2_n_reg;
   logic fdd_reg;
   logic led_reg;
   logic led_oe_n_reg;

   wire logic [15:0] port_base;
   wire logic hit_index;
   wire logic hit_data;
   wire logic wr_data;
   wire logic wr_irq_clk;
   wire logic wr_rom_sel;
   wire logic wr_pin_a;
   wire logic wr_multi_b;
   wire logic [7:0] rd_value;
   wire logic [7:0] strap_rom_bits;
   wire logic in_e;
   wire logic in_f;
   wire logic in_top;
   wire logic in_mid;
   wire logic in_up;
   wire logic rom_hit;
   wire logic irq_any;
   wire logic shared_n;

   // Port pair follows the select bit
   assign port_base = rom_sel_reg[GCM_B_PORT_ALT] ? GCM_PORT_ALT : GCM_PORT_PRI;
   assign hit_index = io_req_i.addr == port_base;
   assign hit_data = io_req_i.addr == (port_base + 16'h0001);
   // Writes in the strap load cycle are dropped so the strap wins once
   assign wr_data = io_req_i.wr && hit_data && !strap_load_reg;
   assign wr_irq_clk = wr_data && (index_reg == GCM_IDX_IRQ_CLK);
   assign wr_rom_sel = wr_data && (index_reg == GCM_IDX_ROM_SEL);
   assign wr_pin_a = wr_data && (index_reg == GCM_IDX_PIN_A);
   assign wr_multi_b = wr_data && (index_reg == GCM_IDX_MULTI_B);

   assign rd_value = hit_index ? index_reg :
                     !hit_data ? 8'h00 :
                     (index_reg == GCM_IDX_IRQ_CLK) ? irq_clk_reg :
                     (index_reg == GCM_IDX_ROM_SEL) ? rom_sel_reg :
                     (index_reg == GCM_IDX_PIN_A) ? pin_a_reg :
                     (index_reg == GCM_IDX_MULTI_B) ? multi_b_reg : 8'h00;

   // Strap image of register 27h
   assign strap_rom_bits = {1'b0,
                            ~flash_if_strap_i,
                            boot_bridge_strap_i,
                            config_port_strap_i,
                            ~decode_window_strap_i,
                            ~decode_window_strap_i,
                            ~decode_window_strap_i,
                            1'b0};

   always_comb begin
      rom_sel_next = rom_sel_reg;
      if (strap_load_reg) begin
         rom_sel_next = strap_rom_bits;
      end else if (wr_rom_sel) begin
         rom_sel_next = io_req_i.wdata & GCM_MASK_ROM_SEL;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         strap_load_reg <= 1'b1;
      end else begin
         strap_load_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         index_reg <= GCM_RST_INDEX;
         irq_clk_reg <= GCM_RST_IRQ_CLK;
         rom_sel_reg <= GCM_RST_ROM_SEL;
         pin_a_reg <= GCM_RST_PIN_A;
      end else begin
         if (io_req_i.wr && hit_index && !strap_load_reg) begin
            index_reg <= io_req_i.wdata;
         end
         if (wr_irq_clk) begin
            irq_clk_reg <= io_req_i.wdata & GCM_MASK_IRQ_CLK;
         end
         rom_sel_reg <= rom_sel_next;
         if (wr_pin_a) begin
            pin_a_reg <= io_req_i.wdata & GCM_MASK_PIN_A;
         end
      end
   end

   // Standby domain: untouched by the main reset
   always_ff @(posedge ref_clk_i) begin
      if (stby_rst_i) begin
         multi_b_reg <= GCM_RST_MULTI_B;
      end else if (wr_multi_b) begin
         multi_b_reg <= io_req_i.wdata & GCM_MASK_MULTI_B;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         io_rdata_reg <= 8'h00;
         io_ack_reg <= 1'b0;
      end else begin
         io_rdata_reg <= io_req_i.rd ? rd_value : io_rdata_reg;
         io_ack_reg <= (io_req_i.rd || io_req_i.wr) && (hit_index || hit_data);
      end
   end

   // Firmware window decode
   assign in_e = (mem_addr_i & GCM_WIN_64K_MASK) == GCM_WIN_E_BASE;
   assign in_f = (mem_addr_i & GCM_WIN_64K_MASK) == GCM_WIN_F_BASE;
   assign in_top = (mem_addr_i & GCM_WIN_512K_MASK) == GCM_WIN_TOP_BASE;
   assign in_mid = (mem_addr_i & GCM_WIN_512K_MASK) == GCM_WIN_MID_BASE;
   assign in_up = (mem_addr_i & GCM_WIN_128K_MASK) == GCM_WIN_UP_BASE;
   assign rom_hit = mem_valid_i && (
      (rom_sel_reg[GCM_B_SEG_E] && in_e) ||
      (rom_sel_reg[GCM_B_TOP512] && (in_top || in_f)) ||
      (rom_sel_reg[GCM_B_UP128] && in_up) ||
      (rom_sel_reg[GCM_B_MID512] && in_mid));

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rom_sel_q_reg <= 1'b0;
         rom_write_q_reg <= 1'b0;
      end else begin
         rom_sel_q_reg <= rom_hit && (!mem_write_i || rom_sel_reg[GCM_B_ROM_WR]);
         rom_write_q_reg <= rom_hit && mem_write_i && rom_sel_reg[GCM_B_ROM_WR];
      end
   end

   // Serial interrupt lines, active low
   assign irq_any = uart1_irq_i || uart2_irq_i;
   // Pulse mode gives one low cycle per rising edge of the merged request
   assign shared_n = irq_clk_reg[GCM_B_IRQ_MODE] ? !(irq_any && !irq_any_reg) : !irq_any;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         irq_any_reg <= 1'b0;
         irq1_n_reg <= 1'b1;
         irq2_n_reg <= 1'b1;
      end else begin
         irq_any_reg <= irq_any;
         if (irq_clk_reg[GCM_B_IRQ_SHARE]) begin
            irq1_n_reg <= shared_n;
            irq2_n_reg <= 1'b1;
         end else begin
            irq1_n_reg <= !uart1_irq_i;
            irq2_n_reg <= !uart2_irq_i;
         end
      end
   end

   // Floppy status and main LED
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         fdd_reg <= 1'b0;
         led_reg <= 1'b0;
         led_oe_n_reg <= 1'b1;
      end else begin
         fdd_reg <= multi_b_reg[GCM_B_FDD_PROT] || !floppy_protect_input_n_i;
         led_reg <= main_supply_led_i;
         led_oe_n_reg <= !(main_power_ok_i || multi_b_reg[GCM_B_LED_RET]);
      end
   end

   assign io_rdata_o = io_rdata_reg;
   assign io_ack_o = io_ack_reg;
   assign rom_sel_o = rom_sel_q_reg;
   assign rom_write_o = rom_write_q_reg;
   assign uart1_irq_n_o = irq1_n_reg;
   assign uart2_irq_n_o = irq2_n_reg;
   assign floppy_protected_o = fdd_reg;
   assign main_supply_led_o = led_reg;
   assign main_supply_led_oe_n_o = led_oe_n_reg;

   assign cfg_o.input_clock_freq_sel = irq_clk_reg[GCM_B_CLK_SEL];
   assign cfg_o.irq_pulse_mode = irq_clk_reg[GCM_B_IRQ_MODE];
   assign cfg_o.serial_irq_share_en = irq_clk_reg[GCM_B_IRQ_SHARE];
   assign cfg_o.flash_if_en = rom_sel_reg[GCM_B_FLASH_IF];
   assign cfg_o.boot_flash_bridge_sel = rom_sel_reg[GCM_B_BRIDGE];
   assign cfg_o.config_port_alt_sel = rom_sel_reg[GCM_B_PORT_ALT];
   // 3 IR receive, 2 IR transmit, 1 fan drive three, 0 fan tach three
   assign cfg_o.pin_gpio_sel = pin_a_reg[3:0];
   assign cfg_o.keyboard_mouse_swap = multi_b_reg[GCM_B_KM_SWAP];
   assign cfg_o.slot_pin_sel = multi_b_reg[GCM_B_SLOT];
   assign cfg_o.watchdog_pin_sel = multi_b_reg[GCM_B_WDOG];
   assign cfg_o.alert_pin_sel = multi_b_reg[GCM_B_ALERT];
endmodule

/* File: gcm_global_config_props.sv */
`timescale 1ns/1ps
module gcm_props (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Watched ports
   input wire gcm_pkg::gcm_io_req_type io_req_i,
   input wire logic io_ack_o,
   input wire logic [31:0] mem_addr_i,
   input wire logic mem_valid_i,
   input wire logic mem_write_i,
   input wire logic rom_sel_o,
   input wire logic rom_write_o,
   input wire logic uart1_irq_i,
   input wire logic uart2_irq_i,
   input wire logic uart1_irq_n_o,
   input wire logic uart2_irq_n_o,
   input wire logic floppy_protect_input_n_i,
   input wire logic floppy_protected_o,
   input wire gcm_pkg::gcm_cfg_type cfg_o
);
   import gcm_pkg::*;
   // Union of all windows; decode enables are not visible here
   wire logic win = mem_addr_i[31:20] == 12'hfff || mem_addr_i[31:17] == 15'h7ff7 || mem_addr_i[31:17] == 15'h0007;
   wire logic shr = cfg_o.serial_irq_share_en;
   wire logic pm = cfg_o.irq_pulse_mode;
   wire logic rq = io_req_i.wr | io_req_i.rd;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   port_ack_a: assert property (rq && !(io_req_i.addr inside {16'h002e, 16'h002f, 16'h004e, 16'h004f})
      |=> !io_ack_o) else $error("ack on foreign port");
   rom_window_a: assert property (rom_sel_o |-> $past(mem_valid_i) && $past(win))
      else $error("rom select outside windows");
   rom_write_a: assert property (rom_write_o |-> rom_sel_o && $past(mem_write_i))
      else $error("rom write without write cycle");
   irq_separate_a: assert property (!shr && !$past(rst_i) |=> uart1_irq_n_o == !$past(uart1_irq_i)
      && uart2_irq_n_o == !$past(uart2_irq_i)) else $error("separate irq mismatch");
   irq_line_two_a: assert property (shr && !$past(rst_i) |=> uart2_irq_n_o)
      else $error("second line active while shared");
   irq_level_a: assert property (shr && !pm && !$past(rst_i) |=>
      uart1_irq_n_o == !($past(uart1_irq_i) || $past(uart2_irq_i))) else $error("shared level mismatch");
   irq_pulse_a: assert property (shr && pm && !uart1_irq_n_o |=> uart1_irq_n_o)
      else $error("shared pulse too long");
   floppy_pin_a: assert property (!$past(rst_i) && $past(!floppy_protect_input_n_i) |-> floppy_protected_o)
      else $error("protect pin not followed");
endmodule
bind gcm_global_config gcm_props u_gcm_props (
   .ref_clk_i(ref_clk_i),
   .rst_i(rst_i),
   .io_req_i(io_req_i),
   .io_ack_o(io_ack_o),
   .mem_addr_i(mem_addr_i),
   .mem_valid_i(mem_valid_i),
   .mem_write_i(mem_write_i),
   .rom_sel_o(rom_sel_o),
   .rom_write_o(rom_write_o),
   .uart1_irq_i(uart1_irq_i),
   .uart2_irq_i(uart2_irq_i),
   .uart1_irq_n_o(uart1_irq_n_o),
   .uart2_irq_n_o(uart2_irq_n_o),
   .floppy_protect_input_n_i(floppy_protect_input_n_i),
   .floppy_protected_o(floppy_protected_o),
   .cfg_o(cfg_o)
);

/* File: tb_gcm_global_config.sv */
`timescale 1ns/1ps
module tb_gcm_global_config;
   import gcm_pkg::*;
   logic ref_clk_i, rst_i, stby_rst_i, flash_if_strap_i, boot_bridge_strap_i, config_port_strap_i;
   logic decode_window_strap_i, mem_valid_i, mem_write_i, rom_sel_o, rom_write_o, uart1_irq_i;
   logic uart2_irq_i, uart1_irq_n_o, uart2_irq_n_o, floppy_protect_input_n_i, floppy_protected_o;
   logic main_power_ok_i, main_supply_led_i, main_supply_led_o, main_supply_led_oe_n_o, io_ack_o;
   logic [7:0] io_rdata_o;
   logic [15:0] base;
   logic [31:0] mem_addr_i;
   gcm_io_req_type io_req_i;
   gcm_cfg_type cfg_o;
   int error_cnt = 0;
   int checks = 0;
   gcm_global_config u_gcm_global_config (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .stby_rst_i(stby_rst_i),
      .flash_if_strap_i(flash_if_strap_i),
      .boot_bridge_strap_i(boot_bridge_strap_i),
      .config_port_strap_i(config_port_strap_i),
      .decode_window_strap_i(decode_window_strap_i),
      .io_req_i(io_req_i),
      .io_rdata_o(io_rdata_o),
      .io_ack_o(io_ack_o),
      .mem_addr_i(mem_addr_i),
      .mem_valid_i(mem_valid_i),
      .mem_write_i(mem_write_i),
      .rom_sel_o(rom_sel_o),
      .rom_write_o(rom_write_o),
      .uart1_irq_i(uart1_irq_i),
      .uart2_irq_i(uart2_irq_i),
      .uart1_irq_n_o(uart1_irq_n_o),
      .uart2_irq_n_o(uart2_irq_n_o),
      .floppy_protect_input_n_i(floppy_protect_input_n_i),
      .floppy_protected_o(floppy_protected_o),
      .main_power_ok_i(main_power_ok_i),
      .main_supply_led_i(main_supply_led_i),
      .main_supply_led_o(main_supply_led_o),
      .main_supply_led_oe_n_o(main_supply_led_oe_n_o),
      .cfg_o(cfg_o)
   );
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic io(logic [15:0] ad, logic [7:0] d, logic w, logic ea);
      @(negedge ref_clk_i);
      io_req_i = '{ad, d, w, !w};
      @(negedge ref_clk_i);
      io_req_i = '0;
      chk("ack", 16'(ea), 16'(io_ack_o));
   endtask
   task automatic wreg(logic [7:0] i, logic [7:0] v);
      io(base, i, 1'b1, 1'b1);
      io(base + 16'h0001, v, 1'b1, 1'b1);
   endtask
   task automatic rreg(logic [7:0] i, logic [7:0] e);
      io(base, i, 1'b1, 1'b1);
      io(base + 16'h0001, 8'h00, 1'b0, 1'b1);
      chk($sformatf("reg %h", i), 16'(e), 16'(io_rdata_o));
   endtask
   task automatic mem(logic [31:0] ad, logic w, logic es, logic ew);
      @(negedge ref_clk_i);
      mem_addr_i = ad;
      mem_valid_i = 1'b1;
      mem_write_i = w;
      @(negedge ref_clk_i);
      mem_valid_i = 1'b0;
      chk("rom_sel", 16'(es), 16'(rom_sel_o));
      chk("rom_write", 16'(ew), 16'(rom_write_o));
   endtask
   task automatic irq(logic a, logic b, logic e1, logic e2);
      @(negedge ref_clk_i);
      uart1_irq_i = a;
      uart2_irq_i = b;
      @(negedge ref_clk_i);
      chk("irq1_n", 16'(e1), 16'(uart1_irq_n_o));
      chk("irq2_n", 16'(e2), 16'(uart2_irq_n_o));
   endtask
   task automatic pin(logic fp, logic pk, logic li, logic ep, logic eoe);
      @(negedge ref_clk_i);
      floppy_protect_input_n_i = fp;
      main_power_ok_i = pk;
      main_supply_led_i = li;
      @(negedge ref_clk_i);
      chk("floppy", 16'(ep), 16'(floppy_protected_o));
      chk("led_oe_n", 16'(eoe), 16'(main_supply_led_oe_n_o));
      if (!eoe) chk("led", 16'(li), 16'(main_supply_led_o));
   endtask
   task stop_test;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Run needs under two hundred cycles; generous margin
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      error_cnt++;
      stop_test();
   end
   initial begin
      {rst_i, stby_rst_i, boot_bridge_strap_i, floppy_protect_input_n_i, main_power_ok_i} = 5'h1f;
      {flash_if_strap_i, config_port_strap_i, decode_window_strap_i, uart1_irq_i, uart2_irq_i} = 5'h00;
      {mem_valid_i, mem_write_i, main_supply_led_i} = 3'h0;
      mem_addr_i = 32'h00000000;
      io_req_i = '0;
      base = 16'h002e;
      repeat (20) @(negedge ref_clk_i);
      rst_i = 1'b0;
      stby_rst_i = 1'b0;
      rreg(8'h26, 8'h00);
      {flash_if_strap_i, decode_window_strap_i} = 2'h3;
      rreg(8'h27, 8'h6e);
      rreg(8'h28, 8'h00);
      rreg(8'h2a, 8'h00);
      chk("cfg", 16'h0600, 16'(cfg_o));
      $display("test reset done");
      wreg(8'h26, 8'hff);
      rreg(8'h26, 8'h83);
      wreg(8'h28, 8'hff);
      rreg(8'h28, 8'h0f);
      wreg(8'h29, 8'hff);
      rreg(8'h29, 8'h77);
      chk("cfg", 16'h3eff, 16'(cfg_o));
      $display("test masks done");
      @(negedge ref_clk_i);
      {flash_if_strap_i, boot_bridge_strap_i, config_port_strap_i, decode_window_strap_i} = 4'hb;
      rst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      base = 16'h004e;
      rreg(8'h27, 8'h10);
      {flash_if_strap_i, boot_bridge_strap_i, config_port_strap_i, decode_window_strap_i} = 4'h4;
      io(16'h002e, 8'h27, 1'b0, 1'b0);
      rreg(8'h27, 8'h10);
      rreg(8'h26, 8'h00);
      rreg(8'h29, 8'h77);
      $display("test second reset done");
      wreg(8'h27, 8'h1e);
      mem(32'h000e0000, 1'b0, 1'b1, 1'b0);
      mem(32'h000dffff, 1'b0, 1'b0, 1'b0);
      mem(32'h000fffff, 1'b0, 1'b1, 1'b0);
      mem(32'hfff80000, 1'b0, 1'b1, 1'b0);
      mem(32'hffffffff, 1'b0, 1'b1, 1'b0);
      mem(32'hffee0000, 1'b0, 1'b1, 1'b0);
      mem(32'hffedffff, 1'b0, 1'b0, 1'b0);
      mem(32'hfff00000, 1'b0, 1'b0, 1'b0);
      mem(32'h000e1234, 1'b1, 1'b0, 1'b0);
      wreg(8'h27, 8'h91);
      mem(32'hfff7ffff, 1'b0, 1'b1, 1'b0);
      mem(32'hfff80000, 1'b0, 1'b0, 1'b0);
      mem(32'h000e0000, 1'b0, 1'b0, 1'b0);
      mem(32'hfff00000, 1'b1, 1'b1, 1'b1);
      $display("test decode done");
      irq(1'b1, 1'b0, 1'b0, 1'b1);
      irq(1'b0, 1'b1, 1'b1, 1'b0);
      irq(1'b0, 1'b0, 1'b1, 1'b1);
      wreg(8'h26, 8'h01);
      irq(1'b0, 1'b1, 1'b0, 1'b1);
      irq(1'b1, 1'b1, 1'b0, 1'b1);
      irq(1'b0, 1'b0, 1'b1, 1'b1);
      wreg(8'h26, 8'h03);
      irq(1'b1, 1'b0, 1'b0, 1'b1);
      irq(1'b1, 1'b1, 1'b1, 1'b1);
      irq(1'b0, 1'b0, 1'b1, 1'b1);
      irq(1'b0, 1'b1, 1'b0, 1'b1);
      $display("test irq done");
      pin(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      wreg(8'h29, 8'h00);
      pin(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      pin(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      pin(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
      $display("test pins done");
      stop_test();
   end
endmodule
